// ===== include/ivt_pkg.sv
// constants, types and trap map for the interrupt vector and trap logic
// Operation
// - Every source has its own request flag, enable flag and trap number, and its vector sits at four times that number.
// - Capture/compare channels 6-15 take trap numbers from 16h, 16-28 take 30h-3Ch and 29-31 take 44h-46h, in channel order.
// - A hardware trap is reacted to at once, whatever any mask or enable says.
// - A hardware trap redirects the program to its own vector exactly like a standard interrupt; here the six class b traps share trap number 0Ah.
// - Each hardware trap sets its own bit in the trap flag register.
// - A hardware trap pre-empts anything except a trap service of higher priority already running; here a running trap service of equal priority also holds it off.
// - Standard interrupts and event-controller transfers cannot pre-empt a running trap service; here a standard interrupt can once a nested trap has ended.
// - Each source has a control register with request flag, enable flag and a sixteen-level priority field.
// - A running interrupt service can only be interrupted by a request of higher priority.
// - Each of the four shared extension vectors has a select register: enables in the upper byte, flags in the lower.
// - A trap service runs at the highest cpu priority level, 15.
package ivt_pkg;
  localparam int NUM_SRC = 56;
  localparam int NUM_XV = 4;
  localparam int NUM_STD = NUM_SRC - NUM_XV;
  localparam int XSRC_W = 8;
  localparam int NUM_TRAP = 9;
  localparam int TRAP_W = 7;
  localparam int VEC_W = 9;
  localparam int LVL_W = 4;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int SRC_IDX_W = 6;
  localparam int TRAP_IDX_W = 4;
  localparam int RANK_W = 3;
  localparam int NUM_STAT = 3;

  localparam logic [LVL_W-1:0] LVL_MAX = 4'hf;
  localparam logic [RANK_W-1:0] RANK_NONE = 3'h0;

  // register map
  localparam logic [ADDR_W-1:0] ADDR_CTL_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTL_LIMIT = ADDR_W'(NUM_SRC);
  localparam logic [ADDR_W-1:0] ADDR_XSEL_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_TFR = 8'h48;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h49;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h4a;

  // source control register fields
  localparam int CTL_IR_BIT = 7;
  localparam int CTL_IE_BIT = 6;
  localparam int CTL_LVL_LSB = 2;
  localparam logic [DATA_W-1:0] RST_REG = 16'h0000;

  // status register bits
  localparam int ST_TRAP = 0;
  localparam int ST_STD = 1;
  localparam int ST_LOST = 2;

  // source index landmarks; index 52..55 are the shared extension vectors
  localparam int IDX_CC6 = 6;
  localparam int IDX_CC16 = 16;
  localparam int IDX_CC29 = 29;
  localparam int IDX_CC31 = 31;
  localparam int IDX_XP0 = NUM_STD;

  // trap number per source index: cc0..cc31, t0 t1 t7 t8, t2..t6, caprel, adc, ade,
  // s0t s0tb s0r s0e, sct scr sce, pwm, xp0..xp3
  localparam logic [TRAP_W-1:0] SRC_TRAP [NUM_SRC] = '{
    7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
    7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h1d, 7'h1e, 7'h1f,
    7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h35, 7'h36, 7'h37,
    7'h38, 7'h39, 7'h3a, 7'h3b, 7'h3c, 7'h44, 7'h45, 7'h46,
    7'h20, 7'h21, 7'h3d, 7'h3e, 7'h22, 7'h23, 7'h24, 7'h25,
    7'h26, 7'h27, 7'h28, 7'h29, 7'h2a, 7'h47, 7'h2b, 7'h2c,
    7'h2d, 7'h2e, 7'h2f, 7'h3f, 7'h40, 7'h41, 7'h42, 7'h43};

  // hardware traps: 0 nmi, 1 stack overflow, 2 stack underflow, 3..8 class b
  localparam logic [TRAP_W-1:0] TRAP_NUM [NUM_TRAP] = '{
    7'h02, 7'h04, 7'h06, 7'h0a, 7'h0a, 7'h0a, 7'h0a, 7'h0a, 7'h0a};
  localparam logic [RANK_W-1:0] TRAP_RANK [NUM_TRAP] = '{
    3'h4, 3'h3, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1};

  typedef logic [NUM_XV-1:0][XSRC_W-1:0] ivt_ext_t;

  typedef struct packed {
    logic valid;
    logic is_trap;
    logic [TRAP_W-1:0] trap_num;
    logic [VEC_W-1:0] vec_addr;
    logic [LVL_W-1:0] level;
  } ivt_vec_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ivt_bus_s;
endpackage

// ===== rtl/ivt_ctrl.sv
// interrupt vectoring and hardware trap arbitration with register port
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module ivt_ctrl (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [ivt_pkg::NUM_STD-1:0] src_req_i,
  input wire ivt_pkg::ivt_ext_t ext_src_i,
  input wire logic [ivt_pkg::NUM_TRAP-1:0] trap_event_i,
  input wire logic [ivt_pkg::LVL_W-1:0] cpu_priority_level_i,
  input wire logic vec_ack_i,
  input wire logic trap_done_i,
  input wire ivt_pkg::ivt_bus_s bus_i,
  output ivt_pkg::ivt_vec_s vec_o,
  output logic [ivt_pkg::DATA_W-1:0] reg_rdata_o,
  output logic irq_o
);
  import ivt_pkg::*;

  // per-source state, gathered from the generate loop
  logic [NUM_SRC-1:0] ir_w;
  logic [NUM_SRC-1:0] ie_w;
  logic [LVL_W-1:0] lvl_w [NUM_SRC];
  logic [NUM_SRC-1:0] set_w;

  logic [DATA_W-1:0] xsel_r [NUM_XV];
  logic [NUM_XV-1:0] xp_any_w;
  logic [NUM_XV-1:0] xp_any_r;
  logic [NUM_XV-1:0] xp_rise_w;

  logic [NUM_TRAP-1:0] trap_flag_register_r;
  logic [NUM_TRAP-1:0] trap_flag_register_nxt;
  logic [NUM_TRAP-1:0] tpend_r;
  logic [NUM_TRAP-1:0] tpend_nxt;
  logic [RANK_W-1:0] trank_r;

  logic [NUM_STAT-1:0] stat_r;
  logic [NUM_STAT-1:0] stat_nxt;
  logic [NUM_STAT-1:0] mask_r;
  logic [NUM_STAT-1:0] mask_nxt;

  ivt_vec_s vec_r;
  ivt_vec_s vec_nxt;
  logic [SRC_IDX_W-1:0] sel_src_r;
  logic [TRAP_IDX_W-1:0] sel_trap_r;
  logic [DATA_W-1:0] rdata_r;
  logic irq_r;

  // register decode
  wire ctl_hit_w = bus_i.addr < ADDR_CTL_LIMIT;
  wire [SRC_IDX_W-1:0] ctl_idx_w = bus_i.addr[SRC_IDX_W-1:0];
  wire xsel_hit_w = bus_i.addr[ADDR_W-1:2] == ADDR_XSEL_BASE[ADDR_W-1:2];
  wire [1:0] xsel_idx_w = bus_i.addr[1:0];
  wire tfr_hit_w = bus_i.addr == ADDR_TFR;
  wire stat_hit_w = bus_i.addr == ADDR_STAT;
  wire mask_hit_w = bus_i.addr == ADDR_MASK;
  wire ctl_wr_w = bus_i.wr && ctl_hit_w;
  wire tfr_wr_w = bus_i.wr && tfr_hit_w;
  wire stat_wr_w = bus_i.wr && stat_hit_w;
  wire mask_wr_w = bus_i.wr && mask_hit_w;

  // a request is taken only while it is offered
  wire ack_w = vec_ack_i && vec_r.valid;
  wire take_std_w = ack_w && !vec_r.is_trap;
  wire take_trap_w = ack_w && vec_r.is_trap;

  // shared extension vectors raise their source request when the OR of their enabled
  // flags rises, so a flag left set does not re-fire after the ack
  assign set_w = {xp_rise_w, src_req_i};
  assign xp_rise_w = xp_any_w & ~xp_any_r;

  genvar g;
  generate
    for (g = 0; g < NUM_XV; g++) begin : g_xv
      wire wr_x = bus_i.wr && xsel_hit_w && xsel_idx_w == 2'(g);
      wire [XSRC_W-1:0] en_x = xsel_r[g][DATA_W-1:XSRC_W];
      wire [XSRC_W-1:0] fl_x = xsel_r[g][XSRC_W-1:0];
      wire [XSRC_W-1:0] clr_x = wr_x ? bus_i.wdata[XSRC_W-1:0] : '0;
      assign xp_any_w[g] = |(en_x & fl_x);
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          xsel_r[g] <= RST_REG;
        end else begin
          xsel_r[g] <= {wr_x ? bus_i.wdata[DATA_W-1:XSRC_W] : en_x, ext_src_i[g] | (fl_x & ~clr_x)};
        end
      end
    end

    for (g = 0; g < NUM_SRC; g++) begin : g_src
      logic ir_q;
      logic ie_q;
      logic [LVL_W-1:0] lvl_q;
      wire wr_s = ctl_wr_w && ctl_idx_w == SRC_IDX_W'(g);
      wire take_s = take_std_w && sel_src_r == SRC_IDX_W'(g);
      // hardware set beats both the ack clear and a software write of zero
      wire ir_nxt = set_w[g] | (wr_s ? bus_i.wdata[CTL_IR_BIT] : (ir_q & ~take_s));
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          ir_q <= 1'b0;
          ie_q <= 1'b0;
          lvl_q <= '0;
        end else begin
          ir_q <= ir_nxt;
          if (wr_s) begin
            ie_q <= bus_i.wdata[CTL_IE_BIT];
            lvl_q <= bus_i.wdata[CTL_LVL_LSB +: LVL_W];
          end
        end
      end
      assign ir_w[g] = ir_q;
      assign ie_w[g] = ie_q;
      assign lvl_w[g] = lvl_q;
    end
  endgenerate

  // standard arbitration: highest level wins, lowest index breaks a tie
  logic std_any_w;
  logic [LVL_W-1:0] std_lvl_w;
  logic [SRC_IDX_W-1:0] std_idx_w;
  always_comb begin
    std_any_w = 1'b0;
    std_lvl_w = '0;
    std_idx_w = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (ir_w[i] && ie_w[i] && (!std_any_w || lvl_w[i] > std_lvl_w)) begin
        std_any_w = 1'b1;
        std_lvl_w = lvl_w[i];
        std_idx_w = SRC_IDX_W'(i);
      end
    end
  end

  // level 0 can never beat the cpu, which matches a disabled priority
  wire std_ok_w = std_any_w && std_lvl_w > cpu_priority_level_i && trank_r == RANK_NONE;

  // trap arbitration ignores every enable and mask
  logic trap_any_w;
  logic [RANK_W-1:0] trap_rank_w;
  logic [TRAP_IDX_W-1:0] trap_idx_w;
  always_comb begin
    trap_any_w = 1'b0;
    trap_rank_w = RANK_NONE;
    trap_idx_w = '0;
    for (int i = 0; i < NUM_TRAP; i++) begin
      if (tpend_r[i] && TRAP_RANK[i] > trap_rank_w) begin
        trap_any_w = 1'b1;
        trap_rank_w = TRAP_RANK[i];
        trap_idx_w = TRAP_IDX_W'(i);
      end
    end
  end

  wire trap_ok_w = trap_any_w && trap_rank_w > trank_r;

  always_comb begin
    vec_nxt = '0;
    if (trap_ok_w) begin
      vec_nxt.valid = 1'b1;
      vec_nxt.is_trap = 1'b1;
      vec_nxt.trap_num = TRAP_NUM[trap_idx_w];
      vec_nxt.level = LVL_MAX;
    end else if (std_ok_w) begin
      vec_nxt.valid = 1'b1;
      vec_nxt.trap_num = SRC_TRAP[std_idx_w];
      vec_nxt.level = std_lvl_w;
    end
    vec_nxt.vec_addr = {vec_nxt.trap_num, 2'b00};
  end

  // trap bookkeeping; the flag register keeps its bits until software writes ones
  assign trap_flag_register_nxt = trap_event_i | (trap_flag_register_r &
    ~(tfr_wr_w ? bus_i.wdata[NUM_TRAP-1:0] : '0));
  assign tpend_nxt = trap_event_i | (tpend_r & ~(take_trap_w ? NUM_TRAP'(1) << sel_trap_r : '0));

  // status events and the interrupt line
  wire [NUM_STAT-1:0] st_set_w = {|(set_w & ir_w), take_std_w, take_trap_w};
  assign stat_nxt = st_set_w | (stat_r & ~(stat_wr_w ? bus_i.wdata[NUM_STAT-1:0] : '0));
  assign mask_nxt = mask_wr_w ? bus_i.wdata[NUM_STAT-1:0] : mask_r;

  // read mux
  wire [DATA_W-1:0] ctl_rd_w = DATA_W'({ir_w[ctl_idx_w], ie_w[ctl_idx_w], lvl_w[ctl_idx_w], 2'b00});
  wire [DATA_W-1:0] rd_val_w =
    ctl_hit_w ? ctl_rd_w :
    xsel_hit_w ? xsel_r[xsel_idx_w] :
    tfr_hit_w ? DATA_W'(trap_flag_register_r) :
    stat_hit_w ? DATA_W'(stat_r) :
    mask_hit_w ? DATA_W'(mask_r) : RST_REG;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      xp_any_r <= '0;
      trap_flag_register_r <= '0;
      tpend_r <= '0;
      stat_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
      rdata_r <= RST_REG;
    end else begin
      xp_any_r <= xp_any_w;
      trap_flag_register_r <= trap_flag_register_nxt;
      tpend_r <= tpend_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= |(stat_nxt & mask_nxt);
      rdata_r <= bus_i.rd ? rd_val_w : RST_REG;
    end
  end

  // offer register; blanked for one cycle after an ack so a stale choice is never shown
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      vec_r <= '0;
      sel_src_r <= '0;
      sel_trap_r <= '0;
    end else begin
      vec_r <= ack_w ? '0 : vec_nxt;
      sel_src_r <= std_idx_w;
      sel_trap_r <= trap_idx_w;
    end
  end

  // single level of trap nesting: a trap ending returns straight to no trap
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      trank_r <= RANK_NONE;
    end else if (take_trap_w) begin
      trank_r <= TRAP_RANK[sel_trap_r];
    end else if (trap_done_i) begin
      trank_r <= RANK_NONE;
    end
  end

  assign vec_o = vec_r;
  assign reg_rdata_o = rdata_r;
  assign irq_o = irq_r;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_trap_seen;
    (|trap_event_i) && trank_r == RANK_NONE;
  endsequence

  sequence s_trap_offered;
    vec_r.valid && vec_r.is_trap;
  endsequence

  sequence s_core_ack;
    vec_ack_i;
  endsequence

  sequence s_trap_pending;
    (|tpend_r) && trank_r == RANK_NONE && !ack_w;
  endsequence

  a_vec_addr_map: assert property (
    vec_r.valid && !vec_r.is_trap |->
      vec_r.trap_num == SRC_TRAP[sel_src_r] && vec_r.vec_addr == VEC_W'({vec_r.trap_num, 2'b00}))
    else $error("standard vector does not match its trap number");

  a_capcom_trap_order: assert property (
    vec_r.valid && !vec_r.is_trap && sel_src_r >= SRC_IDX_W'(IDX_CC29) && sel_src_r <= SRC_IDX_W'(IDX_CC31) |->
      vec_r.trap_num - SRC_TRAP[IDX_CC29] == TRAP_W'(sel_src_r - SRC_IDX_W'(IDX_CC29)))
    else $error("capture channel trap number out of order");

  a_trap_react_fast: assert property (
    s_trap_seen |-> ##[1:3] s_trap_offered)
    else $error("hardware trap not offered within three cycles");

  a_trap_enters_svc: assert property (
    s_core_ack and s_trap_offered |=> trank_r == TRAP_RANK[$past(sel_trap_r)] ##1 !vec_r.valid || vec_r.is_trap)
    else $error("trap service not entered after ack");

  a_trap_flag_set: assert property (
    (|trap_event_i) |=> (trap_flag_register_r & $past(trap_event_i)) == $past(trap_event_i))
    else $error("trap flag bit not set by its trap");

  a_trap_preempt: assert property (
    s_trap_offered |-> TRAP_RANK[sel_trap_r] > $past(trank_r))
    else $error("trap offered over a higher trap service");

  a_trap_blocks_std: assert property (
    trank_r != RANK_NONE |-> !(vec_r.valid && !vec_r.is_trap))
    else $error("standard request offered during trap service");

  a_req_flag_sticky: assert property (
    (|set_w) |=> (ir_w & $past(set_w)) == $past(set_w))
    else $error("request flag lost its hardware set");

  a_std_higher_prio: assert property (
    vec_r.valid && !vec_r.is_trap |-> vec_r.level > $past(cpu_priority_level_i))
    else $error("standard request offered at or below cpu level");

  a_ext_vec_raise: assert property (
    xp_rise_w[0] |=> ir_w[IDX_XP0])
    else $error("shared extension vector request not raised");

  a_trap_top_level: assert property (
    s_trap_offered |-> vec_r.level == LVL_MAX)
    else $error("trap offered below the top level");

  a_trap_flag_hold: assert property (
    (|(trap_flag_register_r & ~$past(trap_flag_register_r)) == 1'b0) &&
      (|($past(trap_flag_register_r) & ~trap_flag_register_r)) |-> $past(tfr_wr_w))
    else $error("trap flag cleared without a software write");

  a_trap_unmasked: assert property (
    s_trap_pending |=> s_trap_offered)
    else $error("pending hardware trap not offered");

  a_tpend_clear: assert property (
    take_trap_w && !trap_event_i[sel_trap_r] |=> !tpend_r[$past(sel_trap_r)])
    else $error("taken trap still pending");

  // a nested trap's end drops straight to no trap, so the outer service runs unguarded
  a_trap_done_clear: assert property (
    trap_done_i && !take_trap_w |=> trank_r == RANK_NONE)
    else $error("trap rank kept after trap done");

  a_vec_blank_ack: assert property (
    ack_w |=> !vec_r.valid)
    else $error("vector still offered after its ack");

  a_std_flag_clear: assert property (
    take_std_w && !set_w[sel_src_r] && !ctl_wr_w |=> !ir_w[$past(sel_src_r)])
    else $error("request flag not cleared by its ack");

  a_std_offer_enabled: assert property (
    vec_r.valid && !vec_r.is_trap |-> $past(ir_w[std_idx_w] && ie_w[std_idx_w]))
    else $error("standard vector offered without flag and enable");

  a_rdata_idle: assert property (
    !bus_i.rd |=> reg_rdata_o == RST_REG)
    else $error("read data shown without a read");

  a_xsel_write: assert property (
    bus_i.wr && xsel_hit_w && xsel_idx_w == 2'h0 && ext_src_i[0] == 8'h00 |=>
      (xsel_r[0][XSRC_W-1:0] & $past(bus_i.wdata[XSRC_W-1:0])) == 8'h00 &&
      xsel_r[0][DATA_W-1:XSRC_W] == $past(bus_i.wdata[DATA_W-1:XSRC_W]))
    else $error("extension select write not applied");

  a_xsel_flag_set: assert property (
    ext_src_i[0] != 8'h00 |=> (xsel_r[0][XSRC_W-1:0] & $past(ext_src_i[0])) == $past(ext_src_i[0]))
    else $error("extension source flag not set");
endmodule

// ===== testbench/ivt_core_model.sv
// core-side partner model: acknowledges each offered vector after a chosen delay
`timescale 1ns/1ps
module ivt_core_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire ivt_pkg::ivt_vec_s vec_i,
  input wire logic [3:0] ack_dly_i,
  output logic vec_ack_o
);
  import ivt_pkg::*;
  logic [3:0] wait_r;
  // the ack drops after one cycle; holding it would take the next winner unseen
  always_ff @(posedge clk_i) begin
    if (reset_i || !vec_i.valid || vec_ack_o) begin
      vec_ack_o <= 1'b0;
      wait_r <= 4'h0;
    end else if (wait_r == ack_dly_i) begin
      vec_ack_o <= 1'b1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// ===== testbench/interrupt_vector_and_trap_logic_tb.sv
// self-checking bench for the interrupt vector and trap logic
`timescale 1ns/1ps
module interrupt_vector_and_trap_logic_tb;
  import ivt_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [NUM_STD-1:0] src_req = '0;
  ivt_ext_t ext_src = '0;
  logic [NUM_TRAP-1:0] trap_ev = '0;
  logic [LVL_W-1:0] cpu_lvl = '0;
  logic trap_done = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  ivt_bus_s bus = '0;
  logic vec_ack;
  ivt_vec_s vec;
  logic [DATA_W-1:0] rdata;
  logic irq;
  int error_cnt = 0;
  int comparisons = 0;

  always #5 clk_i = ~clk_i;

  ivt_ctrl u_dut (.clk_i(clk_i), .reset_i(reset_i), .src_req_i(src_req), .ext_src_i(ext_src),
    .trap_event_i(trap_ev), .cpu_priority_level_i(cpu_lvl), .vec_ack_i(vec_ack), .trap_done_i(trap_done),
    .bus_i(bus), .vec_o(vec), .reg_rdata_o(rdata), .irq_o(irq));
  ivt_core_model u_core (.clk_i(clk_i), .reset_i(reset_i), .vec_i(vec), .ack_dly_i(ack_dly), .vec_ack_o(vec_ack));

  task automatic give_verdict();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    error_cnt++;
    $display("mismatch %s expected event seen timeout", what);
    give_verdict();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask

  task automatic pulse_src(input logic [NUM_STD-1:0] m);
    @(posedge clk_i);
    src_req <= m;
    @(posedge clk_i);
    src_req <= '0;
  endtask

  task automatic pulse_trap(input logic [NUM_TRAP-1:0] m);
    @(posedge clk_i);
    trap_ev <= m;
    @(posedge clk_i);
    trap_ev <= '0;
  endtask

  task automatic pulse_done();
    @(posedge clk_i);
    trap_done <= 1'b1;
    @(posedge clk_i);
    trap_done <= 1'b0;
  endtask

  task automatic expect_none(input int n);
    repeat (n) begin
      tick(1);
      chk("vec_o.valid while blocked", 16'h0000, 16'(vec.valid));
    end
  endtask

  // waits for an offer, checks it, then lets the core model take it
  task automatic expect_vec(input logic [TRAP_W-1:0] tn, input logic [LVL_W-1:0] lv, input logic tr);
    int n;
    n = 0;
    #1;
    while (vec.valid !== 1'b1 && n < 30) begin
      tick(1);
      n++;
    end
    if (n == 30) hang("vec_o.valid");
    chk("vec_o.trap_num", 16'(tn), 16'(vec.trap_num));
    chk("vec_o.vec_addr", 16'({tn, 2'b00}), 16'(vec.vec_addr));
    chk("vec_o.level", 16'(lv), 16'(vec.level));
    chk("vec_o.is_trap", 16'(tr), 16'(vec.is_trap));
    n = 0;
    while (vec_ack !== 1'b1 && n < 30) begin
      tick(1);
      n++;
    end
    if (n == 30) hang("vec_ack");
    tick(1);
    chk("vec_o.valid after ack", 16'h0000, 16'(vec.valid));
  endtask

  task automatic t_reset();
    rd(8'h00, RST_REG, "source control reset");
    rd(ADDR_TFR, RST_REG, "trap flags reset");
    rd(ADDR_STAT, RST_REG, "status reset");
    rd(ADDR_MASK, RST_REG, "mask reset");
    rd(8'h50, 16'h0000, "unmapped read");
    chk("irq_o reset", 16'h0000, 16'(irq));
  endtask

  task automatic t_capcom();
    logic [TRAP_W-1:0] tn;
    logic [DATA_W-1:0] ctl;
    logic [LVL_W-1:0] lv;
    for (int ch = IDX_CC6; ch <= IDX_CC31; ch++) begin
      tn = 7'(ch < 16 ? 'h16 + ch - 6 : ch < 29 ? 'h30 + ch - 16 : 'h44 + ch - 29);
      lv = 4'(1 + ch % 14);
      ctl = 16'h0040 | (16'(lv) << 2);
      ack_dly <= 4'(ch % 2 * 3);
      wr(8'(ch), ctl);
      pulse_src(NUM_STD'(1) << ch);
      expect_vec(tn, lv, 1'b0);
      rd(8'(ch), ctl, "control after service");
    end
  endtask

  task automatic t_ext();
    wr(ADDR_XSEL_BASE, 16'h0100);
    wr(8'(IDX_XP0), 16'h004c);
    @(posedge clk_i);
    ext_src[0][0] <= 1'b1;
    @(posedge clk_i);
    ext_src[0][0] <= 1'b0;
    expect_vec(7'h40, 4'h3, 1'b0);
    @(posedge clk_i);
    ext_src[0][1] <= 1'b1;
    @(posedge clk_i);
    ext_src[0][1] <= 1'b0;
    expect_none(6);
    rd(ADDR_XSEL_BASE, 16'h0103, "ext select flags");
    wr(ADDR_XSEL_BASE, 16'h0103);
    rd(ADDR_XSEL_BASE, 16'h0100, "ext select cleared");
  endtask

  task automatic t_levels();
    @(posedge clk_i);
    cpu_lvl <= 4'h6;
    wr(8'd20, 16'h0058);
    pulse_src(NUM_STD'(1) << 20);
    expect_none(6);
    @(posedge clk_i);
    cpu_lvl <= 4'h5;
    expect_vec(7'h34, 4'h6, 1'b0);
    @(posedge clk_i);
    cpu_lvl <= 4'h0;
    wr(8'd21, 16'h004c);
    wr(8'd22, 16'h0064);
    pulse_src(NUM_STD'(3) << 21);
    expect_vec(7'h36, 4'h9, 1'b0);
    expect_vec(7'h35, 4'h3, 1'b0);
  endtask

  task automatic t_traps();
    @(posedge clk_i);
    cpu_lvl <= 4'hf;
    for (int i = 0; i < NUM_TRAP; i++) begin
      pulse_trap(NUM_TRAP'(1) << i);
      expect_vec(i < 3 ? 7'(2 + 2 * i) : 7'h0a, 4'hf, 1'b1);
      pulse_done();
    end
    rd(ADDR_TFR, 16'h01ff, "trap flags all set");
    wr(ADDR_TFR, 16'h0003);
    rd(ADDR_TFR, 16'h01fc, "trap flags partly cleared");
    wr(ADDR_TFR, 16'h01fc);
    rd(ADDR_TFR, 16'h0000, "trap flags cleared");
    @(posedge clk_i);
    cpu_lvl <= 4'h0;
  endtask

  task automatic t_nest();
    pulse_trap(9'h008);
    expect_vec(7'h0a, 4'hf, 1'b1);
    wr(8'd40, 16'h007c);
    pulse_src(NUM_STD'(1) << 40);
    expect_none(6);
    pulse_trap(9'h001);
    expect_vec(7'h02, 4'hf, 1'b1);
    pulse_trap(9'h002);
    expect_none(6);
    pulse_done();
    expect_vec(7'h04, 4'hf, 1'b1);
    pulse_done();
    expect_vec(7'h26, 4'hf, 1'b0);
    rd(ADDR_STAT, 16'h0003, "status after services");
  endtask

  task automatic t_irq();
    wr(ADDR_STAT, 16'h0007);
    wr(ADDR_MASK, 16'h0000);
    pulse_src(NUM_STD'(1) << 45);
    pulse_src(NUM_STD'(1) << 45);
    rd(ADDR_STAT, 16'h0004, "status second arrival");
    chk("irq_o masked", 16'h0000, 16'(irq));
    wr(ADDR_MASK, 16'h0004);
    tick(2);
    chk("irq_o unmasked", 16'h0001, 16'(irq));
    wr(ADDR_STAT, 16'h0004);
    tick(2);
    chk("irq_o cleared", 16'h0000, 16'(irq));
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_capcom();
    t_ext();
    t_levels();
    t_traps();
    t_nest();
    t_irq();
    give_verdict();
  end
endmodule
